// *** rtl/burst_buffer.sv ***
// Word buffer that releases captured words only in whole bursts
`timescale 1ns/1ps
module burst_buffer
   import image_capture_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              wordValid,   // One captured word
   input  wire logic [WORD_W-1:0] wordData,
   input  wire logic [LEN_W-1:0]  burstLen,    // Burst size allowed by the mask
   output logic                   busValid,    // Write beat offered
   input  wire logic              busReady,
   output logic [WORD_W-1:0]      busData,
   output logic                   busLast,     // Final beat of the burst
   output logic [LEN_W-1:0]       busBurst,    // Length of the burst under way
   output logic                   overflow     // Sticky: a word was dropped
);
   // All state of the buffer
   typedef struct packed {
      logic [BUF_DEPTH-1:0][WORD_W-1:0] mem;
      logic [PTR_W-1:0]                 wrPtr;
      logic [PTR_W-1:0]                 rdPtr;
      burst_state_e                     state;
      logic [LEN_W-1:0]                 beats;   // Beats left in burst
      logic [LEN_W-1:0]                 len;     // Length latched at start
      logic                             ovf;
   } buf_s;

   buf_s                s;       // Current state
   buf_s                next_s;  // Next state
   logic [PTR_W-1:0]    level;   // Words held

   assign level    = s.wrPtr - s.rdPtr;
   assign busValid = (s.state == BB_BURST);
   assign busData  = s.mem[s.rdPtr[PTR_W-2:0]];
   assign busLast  = busValid && (s.beats == LEN_W'(1));
   assign busBurst = s.len;
   assign overflow = s.ovf;

   // Fill, then drain one burst of exactly the latched length
   always_comb begin
      next_s = s;
      // Full buffer drops the word; the bus side stalls too long
      if (wordValid) begin
         if (level < PTR_W'(BUF_DEPTH)) begin
            next_s.mem[s.wrPtr[PTR_W-2:0]] = wordData;
            next_s.wrPtr = s.wrPtr + PTR_W'(1);
         end else begin
            next_s.ovf = 1'b1;
         end
      end
      unique case (s.state)
         BB_IDLE: begin
            // Start only once a whole legal burst is ready [RULE3]
            if (level >= PTR_W'(burstLen)) begin
               next_s.state = BB_BURST;
               next_s.beats = burstLen;
               next_s.len   = burstLen;
            end
         end
         BB_BURST: begin
            if (busReady) begin
               next_s.rdPtr = s.rdPtr + PTR_W'(1);
               next_s.beats = s.beats - LEN_W'(1);
               if (s.beats == LEN_W'(1)) begin
                  next_s.state = BB_IDLE;
               end
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule : burst_buffer

// *** rtl/image_capture_path_config.sv ***
// Image sensor capture front end with codec and preview write paths
`timescale 1ns/1ps
// Operation
// (RULE1) Capture one frame in decimation plus one
// (RULE2) Dual setting runs codec and preview together
// (RULE3) Bursts limited to sizes the mask allows
// (RULE4) Write-only codec enable arms next frame
// (RULE5) Wait line delay pixel clocks per line
// (RULE6) Skip frame delay lines per frame
// (RULE7) Codec pending flag until triggered frame done
module image_capture_path_config
   import image_capture_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Sensor pins, asynchronous to clk
   input  wire logic              pixClk,
   input  wire logic              vsync,
   input  wire logic              hsync,
   input  wire logic [PIX_W-1:0]  pixData,
   // AXI4-Lite slave
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [7:0]        s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // Preview path memory writes
   output logic                   prevWrValid,
   input  wire logic              prevWrReady,
   output logic [WORD_W-1:0]      prevWrData,
   output logic                   prevWrLast,
   output logic [LEN_W-1:0]       prevWrBurst,
   // Codec path memory writes
   output logic                   codecWrValid,
   input  wire logic              codecWrReady,
   output logic [WORD_W-1:0]      codecWrData,
   output logic                   codecWrLast,
   output logic [LEN_W-1:0]       codecWrBurst
);
   localparam int SYN_W = PIX_W + 3;   // Clock, vsync, hsync, data

   // All state of the capture block
   typedef struct packed {
      logic [SYN_W-1:0]   sync1;       // First synchroniser stage
      logic [SYN_W-1:0]   sync2;       // Second synchroniser stage
      logic [2:0]         prevCtl;     // Last clock, vsync, hsync
      logic [DECIM_W-1:0] decim;       // frame_decimation
      logic               dual;        // Both paths at once
      logic [MASK_W-1:0]  mask;        // burst_threshold_mask
      logic               prevEn;      // Preview path enabled
      logic [DELAY_W-1:0] lineDelay;   // line_start_delay
      logic [DELAY_W-1:0] frameDelay;  // frame_start_delay
      logic               codecPending;
      logic               codecFrame;  // Frame goes to codec path
      logic               prevFrame;   // Frame goes to preview path
      logic [DECIM_W-1:0] skipCnt;     // Frames still to discard
      logic [DELAY_W-1:0] lineCnt;     // Lines seen in this frame
      logic               lineOk;      // Current line is past the skip
      logic [DELAY_W-1:0] pixCnt;      // Pixel clocks since line start, held at the line delay
      logic [1:0]         byteIdx;
      logic [WORD_W-1:0]  word;
      logic               wordValid;
      logic               awHeld;
      logic [7:0]         awAddr;
      logic               wHeld;
      logic [31:0]        wData;
      logic [3:0]         wStrb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
   } cap_s;

   cap_s              s;          // Current state
   cap_s              next_s;     // Next state
   logic              ovfPrev;    // Preview buffer dropped a word
   logic              ovfCodec;   // Codec buffer dropped a word
   logic [LEN_W-1:0]  burstLen;   // Burst size for the current mask

   // Smallest burst the threshold mask still permits
   function automatic logic [LEN_W-1:0] burst_for(input logic [MASK_W-1:0] m);
      if (m == MASK_ANY) begin
         return BURST_4;
      end else if (m == MASK_8_UP) begin
         return BURST_8;
      end
      return BURST_16;   // Code 2, and 3 read the same way
   endfunction : burst_for

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   assign burstLen = burst_for(s.mask);   // [RULE3]

   assign s_axi_awready = !s.awHeld && !s.bvalid;
   assign s_axi_wready  = !s.wHeld && !s.bvalid;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_arready = !s.rvalid;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;

   // Sensor timing, frame selection and the register slave
   always_comb begin
      logic        pclkRise;
      logic        vsRise;
      logic        hsRise;
      logic        startCodec;
      logic        capture;
      logic [31:0] cfgWord;
      logic [31:0] dlyWord;
      logic [31:0] stWord;
      logic [31:0] merged;
      merged = '0;
      next_s = s;
      // Two flops before anything reads the pins
      next_s.sync1   = {pixClk, vsync, hsync, pixData};
      next_s.sync2   = s.sync1;
      next_s.prevCtl = s.sync2[SYN_W-1:PIX_W];
      pclkRise = s.sync2[PIX_W+2] && !s.prevCtl[2];
      vsRise   = s.sync2[PIX_W+1] && !s.prevCtl[1];
      hsRise   = s.sync2[PIX_W]   && !s.prevCtl[0];
      next_s.wordValid = 1'b0;
      startCodec = 1'b0;
      capture    = 1'b0;

      // Frame boundary closes the old frame and picks the new one
      if (vsRise) begin
         // Triggered frame is complete: drop the pending flag [RULE7]
         if (s.codecFrame) begin
            next_s.codecPending = 1'b0;
         end
         capture = (s.skipCnt == '0);
         // Keep one, then discard the programmed count [RULE1]
         next_s.skipCnt = capture ? s.decim : s.skipCnt - DECIM_W'(1);
         startCodec = capture && s.codecPending && !s.codecFrame;
         next_s.codecFrame = startCodec;
         // Preview yields to the codec unless both may run [RULE2]
         next_s.prevFrame  = capture && s.prevEn && (s.dual || !startCodec);
         next_s.lineCnt    = '0;
         next_s.lineOk     = 1'b0;
      end

      // Line start: decide whether the frame skip has run out [RULE6]
      if (hsRise) begin
         next_s.lineOk  = (s.lineCnt >= s.frameDelay);
         if (s.lineCnt != '1) begin
            next_s.lineCnt = s.lineCnt + DELAY_W'(1);
         end
         next_s.pixCnt  = '0;
         next_s.byteIdx = '0;
      end else if (pclkRise && s.sync2[PIX_W]) begin
         // Pixels count only after the line delay ran out [RULE5]
         if (s.pixCnt < s.lineDelay) begin
            next_s.pixCnt = s.pixCnt + DELAY_W'(1);
         end else if (s.lineOk && (s.codecFrame || s.prevFrame)) begin
            next_s.word[s.byteIdx*PIX_W +: PIX_W] = s.sync2[PIX_W-1:0];
            next_s.byteIdx   = s.byteIdx + 2'h1;
            next_s.wordValid = (s.byteIdx == 2'h3);
         end
      end

      // Register images
      cfgWord = '0;
      cfgWord[CFG_DECIM_LSB +: DECIM_W] = s.decim;
      cfgWord[CFG_DUAL_BIT]             = s.dual;
      cfgWord[CFG_MASK_LSB +: MASK_W]   = s.mask;
      cfgWord[CFG_PREV_BIT]             = s.prevEn;
      dlyWord = '0;
      dlyWord[DLY_LINE_LSB +: DELAY_W]  = s.lineDelay;
      dlyWord[DLY_FRAME_LSB +: DELAY_W] = s.frameDelay;
      stWord = '0;
      stWord[ST_PEND_BIT]  = s.codecPending;
      stWord[ST_CODEC_BIT] = s.codecFrame;
      stWord[ST_PREV_BIT]  = s.prevFrame;
      stWord[ST_OVF_P_BIT] = ovfPrev;
      stWord[ST_OVF_C_BIT] = ovfCodec;

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && !s.awHeld && !s.bvalid) begin
         next_s.awHeld = 1'b1;
         next_s.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.wHeld && !s.bvalid) begin
         next_s.wHeld = 1'b1;
         next_s.wData = s_axi_wdata;
         next_s.wStrb = s_axi_wstrb;
      end
      if (s.awHeld && s.wHeld) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         unique case (s.awAddr)
            OFS_CONFIG: begin
               merged = merge(cfgWord, s.wData, s.wStrb);
               next_s.decim  = merged[CFG_DECIM_LSB +: DECIM_W];
               next_s.dual   = merged[CFG_DUAL_BIT];
               next_s.mask   = merged[CFG_MASK_LSB +: MASK_W];
               next_s.prevEn = merged[CFG_PREV_BIT];
            end
            OFS_CONTROL: begin
               // Writing one arms the codec; set beats a same-cycle clear
               if (s.wStrb[0] && s.wData[CTL_CODEC_BIT]) begin
                  next_s.codecPending = 1'b1;   // [RULE4] [RULE7]
               end
            end
            OFS_DELAYS: begin
               merged = merge(dlyWord, s.wData, s.wStrb);
               next_s.lineDelay  = merged[DLY_LINE_LSB +: DELAY_W];
               next_s.frameDelay = merged[DLY_FRAME_LSB +: DELAY_W];
            end
            OFS_STATUS: begin
               // Status is read-only; the write is ignored
            end
            default: begin
               next_s.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // Read channel: one-cycle answer, control word reads as zero
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s.rvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_CONFIG:  next_s.rdata = cfgWord;
            OFS_CONTROL: next_s.rdata = '0;
            OFS_DELAYS:  next_s.rdata = dlyWord;
            OFS_STATUS:  next_s.rdata = stWord;
            default: begin
               next_s.rdata = '0;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Preview path buffer
   burst_buffer prevBuf (
      .clk       (clk),
      .rst_b     (rst_b),
      .wordValid (s.wordValid && s.prevFrame),   // [RULE2]
      .wordData  (s.word),
      .burstLen  (burstLen),
      .busValid  (prevWrValid),
      .busReady  (prevWrReady),
      .busData   (prevWrData),
      .busLast   (prevWrLast),
      .busBurst  (prevWrBurst),
      .overflow  (ovfPrev)
   );

   // Codec path buffer
   burst_buffer codecBuf (
      .clk       (clk),
      .rst_b     (rst_b),
      .wordValid (s.wordValid && s.codecFrame),  // [RULE2]
      .wordData  (s.word),
      .burstLen  (burstLen),
      .busValid  (codecWrValid),
      .busReady  (codecWrReady),
      .busData   (codecWrData),
      .busLast   (codecWrLast),
      .busBurst  (codecWrBurst),
      .overflow  (ovfCodec)
   );
endmodule : image_capture_path_config

// *** rtl/image_capture_pkg.sv ***
// Constants shared by the image capture path and its burst buffer
package image_capture_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_CONFIG  = 8'h00;
   localparam logic [7:0] OFS_CONTROL = 8'h04;
   localparam logic [7:0] OFS_DELAYS  = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0C;

   // Field positions in the configuration word
   localparam int CFG_DECIM_LSB = 0;
   localparam int CFG_DUAL_BIT  = 3;
   localparam int CFG_MASK_LSB  = 4;
   localparam int CFG_PREV_BIT  = 6;
   // Field positions in the control and delay words
   localparam int CTL_CODEC_BIT = 0;
   localparam int DLY_LINE_LSB  = 0;
   localparam int DLY_FRAME_LSB = 16;
   // Field positions in the status word
   localparam int ST_PEND_BIT   = 0;
   localparam int ST_CODEC_BIT  = 1;
   localparam int ST_PREV_BIT   = 2;
   localparam int ST_OVF_P_BIT  = 3;
   localparam int ST_OVF_C_BIT  = 4;

   // Widths
   localparam int DECIM_W = 3;
   localparam int MASK_W  = 2;
   localparam int DELAY_W = 8;
   localparam int LEN_W   = 5;
   localparam int PIX_W   = 8;
   localparam int WORD_W  = 32;

   // Burst threshold mask codes and the bursts they imply
   localparam logic [MASK_W-1:0] MASK_ANY   = 2'h0;
   localparam logic [MASK_W-1:0] MASK_8_UP  = 2'h1;
   localparam logic [LEN_W-1:0]  BURST_4    = 5'h04;
   localparam logic [LEN_W-1:0]  BURST_8    = 5'h08;
   localparam logic [LEN_W-1:0]  BURST_16   = 5'h10;

   // Buffer depth: two longest bursts so one fills while one drains
   localparam int BUF_DEPTH = 32;
   localparam int PTR_W     = 6;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Burst buffer states, Gray coded
   typedef enum logic [0:0] {
      BB_IDLE  = 1'h0,
      BB_BURST = 1'h1
   } burst_state_e;
endpackage : image_capture_pkg

// *** test/image_capture_path_config_bench.sv ***
// Self-checking bench for the capture path configuration
`timescale 1ns/1ps
module image_capture_path_config_bench;
   import image_capture_pkg::*;
   logic clk, rst_b, pixClk, vsync, hsync;
   logic [PIX_W-1:0] pixData;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic prevWrValid, prevWrReady, prevWrLast, codecWrValid, codecWrReady, codecWrLast;
   logic [WORD_W-1:0] prevWrData, codecWrData;
   logic [LEN_W-1:0] prevWrBurst, codecWrBurst;
   logic [36:0] pq[$], cq[$]; // Accepted beats: burst length and word
   int errCount = 0, checkCount = 0, cycles = 0;

   image_capture_path_config image_capture_path_config_i (.clk(clk), .rst_b(rst_b),
      .pixClk(pixClk), .vsync(vsync), .hsync(hsync), .pixData(pixData),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .prevWrValid(prevWrValid),
      .prevWrReady(prevWrReady), .prevWrData(prevWrData), .prevWrLast(prevWrLast),
      .prevWrBurst(prevWrBurst), .codecWrValid(codecWrValid), .codecWrReady(codecWrReady),
      .codecWrData(codecWrData), .codecWrLast(codecWrLast), .codecWrBurst(codecWrBurst));
   image_sensor_model image_sensor_model_i (.pixClk(pixClk), .vsync(vsync), .hsync(hsync),
      .pixData(pixData));

   always #10 clk = ~clk; // 50 MHz

   // Memory stalls per path, and the hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      prevWrReady  <= (cycles % 5) != 2;
      codecWrReady <= (cycles % 7) != 3;
      if (prevWrValid && prevWrReady) pq.push_back({prevWrBurst, prevWrData});
      if (codecWrValid && codecWrReady) cq.push_back({codecWrBurst, codecWrData});
      if (cycles == 60000) begin
         errCount++;
         give_verdict();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errCount++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Write both channels together, release each once taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic awDone = 1'b0, wDone = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) awDone = 1'b1;
         if (s_axi_wvalid && s_axi_wready) wDone = 1'b1;
         if (awDone) s_axi_awvalid <= 1'b0;
         if (wDone) s_axi_wvalid <= 1'b0;
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task axi_read(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // Wait for n beats on one path, then compare count, words and lengths
   task automatic take(input logic cdc, input int n, input logic [7:0] s, input logic [4:0] len);
      logic [36:0] b;
      int k = 0;
      while ((cdc ? cq.size() : pq.size()) < n && k < 3000) begin
         @(posedge clk);
         k++;
      end
      repeat (60) @(posedge clk); // Room for stray beats
      check(32'(cdc ? cq.size() : pq.size()), 32'(n));
      for (int i = 0; i < n; i++) begin
         b = cdc ? cq[i] : pq[i];
         check(b[31:0], {s + 8'h03, s + 8'h02, s + 8'h01, s});
         check(32'(b[36:32]), 32'(len));
         s = s + 8'h04;
      end
      if (cdc) cq.delete();
      else pq.delete();
   endtask : take

   task give_verdict;
      $display("checks %0d mismatches %0d", checkCount, errCount);
      if (errCount == 0 && checkCount > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   initial begin
      {clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      // Reset values, write-only control, unmapped place
      axi_read(OFS_CONFIG);
      check(rd, 32'h0000_0000);
      axi_read(OFS_CONTROL);
      check(rd, 32'h0000_0000);
      axi_read(OFS_STATUS);
      check(32'(rd[ST_PEND_BIT]), 32'h0);
      axi_read(8'h10);
      check(32'(rsp), 32'(RESP_SLVERR));
      axi_write(8'h10, 32'h0);
      check(32'(rsp), 32'(RESP_SLVERR));
      $display("test registers done");
      // Mask codes 0 to 2, each with a frame of exactly one allowed burst
      for (int m = 0; m < 3; m++) begin
         axi_write(OFS_CONFIG, 32'h40 | (m << CFG_MASK_LSB));
         image_sensor_model_i.send_frame(1, 16 << m, 8'(m * 16));
         take(1'b0, 4 << m, 8'(m * 16), 5'(4 << m));
      end
      $display("test burst mask done");
      // Two pixel clocks and one line skipped
      axi_write(OFS_CONFIG, 32'h40);
      axi_write(OFS_DELAYS, 32'h0001_0002);
      image_sensor_model_i.send_frame(2, 18, 8'h00);
      take(1'b0, 4, 8'h14, 5'h04);
      axi_write(OFS_DELAYS, 32'h0);
      $display("test start delays done");
      // Three frames with decimation two: one lands whatever the phase
      axi_write(OFS_CONFIG, 32'h42);
      repeat (3) image_sensor_model_i.send_frame(1, 16, 8'h00);
      take(1'b0, 4, 8'h00, 5'h04);
      axi_write(OFS_CONFIG, 32'h40);
      $display("test decimation done");
      // Zero has no effect, one arms the next frame for the codec
      axi_write(OFS_CONTROL, 32'h0);
      axi_read(OFS_STATUS);
      check(32'(rd[ST_PEND_BIT]), 32'h0);
      for (int d = 0; d < 2; d++) begin
         axi_write(OFS_CONFIG, 32'h40 | (d << CFG_DUAL_BIT));
         axi_write(OFS_CONTROL, 32'h1);
         axi_read(OFS_STATUS);
         check(32'(rd[ST_PEND_BIT]), 32'h1);
         image_sensor_model_i.send_frame(1, 16, 8'h60);
         image_sensor_model_i.send_frame(0, 0, 8'h00);
         take(1'b1, 4, 8'h60, 5'h04);
         take(1'b0, 4 * d, 8'h60, 5'h04);
         axi_read(OFS_STATUS);
         check(32'(rd[ST_PEND_BIT]), 32'h0);
      end
      $display("test codec trigger done");
      give_verdict();
   end
endmodule : image_capture_path_config_bench

// *** test/image_capture_path_config_chk.sv ***
// Concurrent checks on the bus and write-burst ports of the capture block
`timescale 1ns/1ps
module image_capture_path_config_chk
   import image_capture_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_b,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid,
   input wire logic             prevWrValid,
   input wire logic             prevWrReady,
   input wire logic [WORD_W-1:0] prevWrData,
   input wire logic             prevWrLast,
   input wire logic [LEN_W-1:0] prevWrBurst,
   input wire logic             codecWrValid,
   input wire logic             codecWrReady,
   input wire logic             codecWrLast,
   input wire logic [LEN_W-1:0] codecWrBurst
);
   logic [LEN_W-1:0] prevBeat;  // Beats moved so far in the preview burst
   logic [LEN_W-1:0] codecBeat; // Beats moved so far in the codec burst

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // Beat counters restart after every final beat
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prevBeat  <= '0;
         codecBeat <= '0;
      end else begin
         if (prevWrValid && prevWrReady) prevBeat <= prevWrLast ? '0 : prevBeat + 5'h01;
         if (codecWrValid && codecWrReady) codecBeat <= codecWrLast ? '0 : codecBeat + 5'h01;
      end
   end

   // Address and data taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_prev_burst_legal: assert property (prevWrValid |-> prevWrBurst inside {5'h04, 5'h08, 5'h10})
      else $error("preview burst length illegal");
   a_codec_burst_legal: assert property (codecWrValid |-> codecWrBurst inside {5'h04, 5'h08, 5'h10})
      else $error("codec burst length illegal");
   a_prev_beat_hold: assert property (prevWrValid && !prevWrReady |=>
      prevWrValid && $stable(prevWrData) && $stable(prevWrBurst))
      else $error("preview beat changed while stalled");
   a_prev_last_count: assert property (prevWrValid && prevWrReady |->
      prevWrLast == (prevBeat == prevWrBurst - 5'h01))
      else $error("preview last beat misplaced");
   a_codec_last_count: assert property (codecWrValid && codecWrReady |->
      codecWrLast == (codecBeat == codecWrBurst - 5'h01))
      else $error("codec last beat misplaced");
endmodule : image_capture_path_config_chk

bind image_capture_path_config image_capture_path_config_chk image_capture_path_config_chk_i (
   .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .prevWrValid(prevWrValid), .prevWrReady(prevWrReady),
   .prevWrData(prevWrData), .prevWrLast(prevWrLast), .prevWrBurst(prevWrBurst),
   .codecWrValid(codecWrValid), .codecWrReady(codecWrReady), .codecWrLast(codecWrLast),
   .codecWrBurst(codecWrBurst));

// *** test/image_sensor_model.sv ***
// Behavioural image sensor that sends frames, lines and pixels
`timescale 1ns/1ps
module image_sensor_model
   import image_capture_pkg::*;
(
   output logic             pixClk,   // Stands still low outside lines
   output logic             vsync,    // Frame start on rising edge
   output logic             hsync,    // High while a line is sent
   output logic [PIX_W-1:0] pixData   // Pixel byte
);
   localparam int HALF = 60; // Each level lasts three system clocks

   // Idle levels from time zero
   initial begin
      pixClk  = 1'b0;
      vsync   = 1'b0;
      hsync   = 1'b0;
      pixData = 8'h00;
   end

   // One frame: vsync pulse, then lines of counting pixels from base
   task automatic send_frame(input int lines, input int pix, input logic [7:0] base);
      logic [7:0] v;
      v = base;
      #7 vsync = 1'b1; // Offset keeps edges clear of the system clock
      #(4*HALF) vsync = 1'b0;
      for (int l = 0; l < lines; l++) begin
         #(2*HALF) hsync = 1'b1;
         for (int p = 0; p < pix; p++) begin
            pixData = v;
            #HALF pixClk = 1'b1;
            #HALF pixClk = 1'b0;
            v = v + 8'h01;
         end
         hsync = 1'b0;
         pixData = ~pixData; // Released bus never shows the last pixel
      end
      #(2*HALF);
   endtask : send_frame
endmodule : image_sensor_model
